/* File: logic/lcd_port_params.svh */
/*
   Constants of the display memory command port: command codes, reset values and memory shape.
   Assumes it is included by bare name wherever these constants are used.
*/
`ifndef LCD_PORT_PARAMS_SVH
`define LCD_PORT_PARAMS_SVH

// Command codes decoded by the port itself.
`define CMD_RMW_ENTER 8'he0
`define CMD_RMW_END 8'hee
`define CMD_SOFT_RESET 8'he2

// Memory shape: columns 0 to 0x50 inclusive, four pages.
`define COL_COUNT 81
`define PAGE_COUNT 4

// Values loaded by the software reset command.
`define PAGE_SOFT_RESET 2'b11
`define START_SOFT_RESET 5'h00

// Values after hardware reset.
`define COLUMN_RESET 7'h00
`define PAGE_RESET 2'b00
`define START_RESET 5'h00
`define LATCH_RESET 8'h00

// Status byte: busy flag sits on data bit 7.
`define STATUS_BUSY_BIT 7

`endif

/* File: logic/lcd_port_pkg.sv */
/*
   Types shared by the command port and its buffer.
   Assumes nothing beyond a SystemVerilog compiler.
*/
package lcd_port_pkg;

   // Decoded level of the host control pins.
   typedef enum logic [4:0] {
      BUS_IDLE = 5'b00001,
      BUS_WDATA = 5'b00010,
      BUS_RDATA = 5'b00100,
      BUS_WCMD = 5'b01000,
      BUS_RSTAT = 5'b10000
   } bus_kind_type;

   // Kind of operation queued for execution.
   typedef enum logic [2:0] {
      OP_WDATA = 3'b001,
      OP_RDATA = 3'b010,
      OP_CMD = 3'b100
   } op_kind_type;

   // One queued host access.
   typedef struct packed {
      op_kind_type op;
      logic [7:0] data;
   } op_entry_type;

endpackage

/* File: logic/op_buffer.sv */
/*
   Small valid/ready buffer built from flip-flops, addressed by index.
   Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module op_buffer #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // The pointers wrap naturally, so the depth must be a power of two.
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_shape
      $error("op_buffer: DEPTH must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] store_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;

   // Full and empty come straight from the occupancy count.
   assign in_ready = (count_r != (AW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign out_data = store_r[rd_ptr_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Pointers and count.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end

   // Storage carries data only, so it needs no reset.
   always_ff @(posedge clk) begin
      if (push) begin
         store_r[wr_ptr_r] <= in_data;
      end
   end

endmodule

/* File: logic/lcd_command_port.sv */
/*
   Host command and data port of a graphic display column driver: display memory, column and page
   pointers, read latch, read-modify-write mode and software reset.
   Assumes host pins arrive asynchronously and are synchronised here; the set-up command decoder
   and its register loads run on CLOCK.
*/
`timescale 1ns/1ps
`include "lcd_port_params.svh"
module lcd_command_port #(
   parameter int COLS = `COL_COUNT
) (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic CMD_DATA_SEL,
   input wire logic ENABLE_READ,
   input wire logic READ_WRITE_SEL,
   input wire logic [7:0] PARALLEL_DATA_LINES_IN,
   output logic [7:0] PARALLEL_DATA_LINES_OUT,
   output logic PARALLEL_DATA_LINES_OE,
   output logic BUSY,
   output logic [6:0] COLUMN,
   output logic [1:0] PAGE,
   output logic [4:0] START_LINE,
   output logic RMW_ACTIVE,
   output logic SETUP_VALID,
   output logic [7:0] SETUP_CODE,
   input wire logic SETUP_READY,
   input wire logic COLUMN_LOAD,
   input wire logic [6:0] COLUMN_VALUE,
   input wire logic PAGE_LOAD,
   input wire logic [1:0] PAGE_VALUE,
   input wire logic START_LINE_LOAD,
   input wire logic [4:0] START_LINE_VALUE
);
   import lcd_port_pkg::*;

   localparam int DEPTH = COLS * `PAGE_COUNT;
   localparam int IW = $clog2(DEPTH);
   localparam logic [6:0] COL_LAST = 7'(COLS - 1);

   // The column counter is 7 bits wide, so at most 128 columns can be served.
   if (COLS < 1 || COLS > 128) begin : g_bad_cols
      $error("lcd_command_port: COLS must lie between 1 and 128");
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Helpers.

   // Maps the control pins to an access kind; status read is select low with read/write high.
   function automatic bus_kind_type decode_bus(input logic cd, input logic en, input logic rw);
      case ({cd, en, rw})
         3'b110: decode_bus = BUS_WDATA;
         3'b101: decode_bus = BUS_RDATA;
         3'b010: decode_bus = BUS_WCMD;
         3'b001: decode_bus = BUS_RSTAT;
         default: decode_bus = BUS_IDLE;
      endcase
   endfunction

   // Column step that stops at the last valid column.
   function automatic logic [6:0] col_step(input logic [6:0] col);
      col_step = (col >= COL_LAST) ? COL_LAST : col + 7'h01;
   endfunction

   // Flat memory index of a page and column.
   function automatic logic [IW-1:0] mem_index(input logic [1:0] page, input logic [6:0] col);
      mem_index = IW'(page * COLS + col);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Pin synchroniser: a change counts once the second and third stages agree.

   logic [10:0] sync1_r;
   logic [10:0] sync2_r;
   logic [10:0] sync3_r;
   logic [10:0] stable_r;

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         sync1_r <= 11'h000;
         sync2_r <= 11'h000;
         sync3_r <= 11'h000;
         stable_r <= 11'h000;
      end else begin
         sync1_r <= {CMD_DATA_SEL, ENABLE_READ, READ_WRITE_SEL, PARALLEL_DATA_LINES_IN};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         if (sync2_r == sync3_r) begin
            stable_r <= sync3_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Access detection. Writes are taken when the write level ends, so late data setup still counts.

   bus_kind_type kind_now;
   bus_kind_type kind_r;
   logic [7:0] wdata_r;
   logic push_valid;
   op_entry_type push_entry;
   logic push_ready;

   assign kind_now = decode_bus(stable_r[10], stable_r[9], stable_r[8]);

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         kind_r <= BUS_IDLE;
         wdata_r <= 8'h00;
      end else begin
         kind_r <= kind_now;
         if (kind_now == BUS_WDATA || kind_now == BUS_WCMD) begin
            wdata_r <= stable_r[7:0];
         end
      end
   end

   // One entry is offered at the end of each write or data read; a full buffer drops it.
   always_comb begin
      push_valid = 1'b0;
      push_entry = '{op: OP_CMD, data: wdata_r};
      if (kind_r != kind_now) begin
         case (kind_r)
            BUS_WDATA: begin
               push_valid = 1'b1;
               push_entry = '{op: OP_WDATA, data: wdata_r};
            end
            BUS_RDATA: begin
               push_valid = 1'b1;
               push_entry = '{op: OP_RDATA, data: wdata_r};
            end
            BUS_WCMD: begin
               push_valid = 1'b1;
            end
            default: begin
               push_valid = 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Operation buffer. Its fullness is the busy flag, so a stalled set-up decoder refuses the host.

   logic pop_valid;
   logic pop_ready;
   logic [$bits(op_entry_type)-1:0] pop_bits;
   op_entry_type pop_entry;
   logic pop;
   logic setup_valid_r;

   op_buffer #(
      .WIDTH($bits(op_entry_type)),
      .DEPTH(2)
   ) u_buffer (
      .clk(CLOCK),
      .rst_n(RST_N),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data(push_entry),
      .out_valid(pop_valid),
      .out_ready(pop_ready),
      .out_data(pop_bits)
   );

   assign pop_entry = op_entry_type'(pop_bits);
   assign pop_ready = !setup_valid_r;
   assign pop = pop_valid && pop_ready;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Display memory and read latch. Memory has no reset; no command ever clears it.

   logic [7:0] mem_r [DEPTH];
   logic [7:0] latch_r;
   logic [6:0] column_r;
   logic [1:0] page_r;

   always_ff @(posedge CLOCK) begin
      if (pop && pop_entry.op == OP_WDATA) begin
         mem_r[mem_index(page_r, column_r)] <= pop_entry.data;
      end
   end

   // The latch is refilled after the read ends, so each read shows the previous byte.
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         latch_r <= `LATCH_RESET;
      end else if (pop && pop_entry.op == OP_RDATA) begin
         latch_r <= mem_r[mem_index(page_r, column_r)];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Column counter and read-modify-write mode.

   logic rmw_r;
   logic [6:0] saved_col_r;
   logic is_cmd;

   assign is_cmd = pop && pop_entry.op == OP_CMD;

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         column_r <= `COLUMN_RESET;
      end else if (pop && pop_entry.op == OP_WDATA) begin
         column_r <= col_step(column_r);
      end else if (pop && pop_entry.op == OP_RDATA) begin
         if (!rmw_r) begin
            column_r <= col_step(column_r);
         end
      end else if (is_cmd && pop_entry.data == `CMD_RMW_END && rmw_r) begin
         column_r <= saved_col_r;
      end else if (COLUMN_LOAD) begin
         column_r <= (COLUMN_VALUE > COL_LAST) ? COL_LAST : COLUMN_VALUE;
      end
   end

   // Mode flag and saved column; untouched by any other command code.
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rmw_r <= 1'b0;
         saved_col_r <= `COLUMN_RESET;
      end else if (is_cmd && pop_entry.data == `CMD_RMW_ENTER) begin
         rmw_r <= 1'b1;
         saved_col_r <= column_r;
      end else if (is_cmd && pop_entry.data == `CMD_RMW_END) begin
         rmw_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Page and start line: software reset touches only these two.

   logic [4:0] start_r;

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         page_r <= `PAGE_RESET;
         start_r <= `START_RESET;
      end else if (is_cmd && pop_entry.data == `CMD_SOFT_RESET) begin
         page_r <= `PAGE_SOFT_RESET;
         start_r <= `START_SOFT_RESET;
      end else begin
         if (PAGE_LOAD) begin
            page_r <= PAGE_VALUE;
         end
         if (START_LINE_LOAD) begin
            start_r <= START_LINE_VALUE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Hand-off of other command codes; the buffer stalls until the decoder takes each one.

   logic [7:0] setup_code_r;

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         setup_valid_r <= 1'b0;
         setup_code_r <= 8'h00;
      end else if (is_cmd && pop_entry.data != `CMD_RMW_ENTER && pop_entry.data != `CMD_RMW_END
                   && pop_entry.data != `CMD_SOFT_RESET) begin
         setup_valid_r <= 1'b1;
         setup_code_r <= pop_entry.data;
      end else if (SETUP_READY) begin
         setup_valid_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Pin drive and registered outputs. The bus is driven only during a read level.

   logic [7:0] dout_r;
   logic doe_r;
   logic busy_r;

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         dout_r <= 8'h00;
         doe_r <= 1'b0;
         busy_r <= 1'b0;
      end else begin
         doe_r <= (kind_now == BUS_RDATA) || (kind_now == BUS_RSTAT);
         busy_r <= !push_ready;
         if (kind_now == BUS_RSTAT) begin
            dout_r <= 8'h00;
            dout_r[`STATUS_BUSY_BIT] <= !push_ready;
         end else begin
            dout_r <= latch_r;
         end
      end
   end

   assign PARALLEL_DATA_LINES_OUT = dout_r;
   assign PARALLEL_DATA_LINES_OE = doe_r;
   assign BUSY = busy_r;
   assign COLUMN = column_r;
   assign PAGE = page_r;
   assign START_LINE = start_r;
   assign RMW_ACTIVE = rmw_r;
   assign SETUP_VALID = setup_valid_r;
   assign SETUP_CODE = setup_code_r;

endmodule

/* File: verification/lcd_port_props.sv */
/*
   Checker for the command port: column stepping, soft reset loads, status and set-up hand-off.
   Assumes it is bound to lcd_command_port and that everything runs on CLOCK.
*/
`timescale 1ns/1ps
module lcd_port_props #(
   parameter int COLS = 81
) (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic CMD_DATA_SEL,
   input wire logic ENABLE_READ,
   input wire logic READ_WRITE_SEL,
   input wire logic [7:0] PARALLEL_DATA_LINES_OUT,
   input wire logic PARALLEL_DATA_LINES_OE,
   input wire logic [6:0] COLUMN,
   input wire logic [1:0] PAGE,
   input wire logic [4:0] START_LINE,
   input wire logic RMW_ACTIVE,
   input wire logic SETUP_VALID,
   input wire logic [7:0] SETUP_CODE,
   input wire logic SETUP_READY,
   input wire logic COLUMN_LOAD,
   input wire logic PAGE_LOAD,
   input wire logic START_LINE_LOAD
);
   logic rmw_r;
   logic [6:0] saved_r;
   logic [2:0] pins;
   assign pins = {CMD_DATA_SEL, ENABLE_READ, READ_WRITE_SEL};
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RST_N);
   // Keep our own copy of the column seen on mode entry, to judge the restore on exit.
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rmw_r <= 1'b0;
         saved_r <= 7'h00;
      end else begin
         rmw_r <= RMW_ACTIVE;
         if (RMW_ACTIVE && !rmw_r) begin
            saved_r <= COLUMN;
         end
      end
   end
   //////////////////////////////////////////////////////////////////////
   property p_col_max;
      COLUMN <= 7'(COLS - 1);
   endproperty
   a_col_max: assert property (p_col_max) else $error("column beyond last");
   property p_col_step;
      (COLUMN != $past(COLUMN)) && !$past(COLUMN_LOAD) && !$fell(RMW_ACTIVE) |-> COLUMN == $past(COLUMN) + 7'h01;
   endproperty
   a_col_step: assert property (p_col_step) else $error("column moved by other than one");
   property p_start_soft;
      (START_LINE != $past(START_LINE)) && !$past(START_LINE_LOAD) |-> START_LINE == 5'h00 && PAGE == 2'b11;
   endproperty
   a_start_soft: assert property (p_start_soft) else $error("start line changed wrongly");
   property p_page_soft;
      (PAGE != $past(PAGE)) && !$past(PAGE_LOAD) |-> PAGE == 2'b11 && START_LINE == 5'h00;
   endproperty
   a_page_soft: assert property (p_page_soft) else $error("page changed wrongly");
   property p_status;
      (pins == 3'b001) [*8] |-> PARALLEL_DATA_LINES_OE && PARALLEL_DATA_LINES_OUT[6:0] == 7'h00;
   endproperty
   a_status: assert property (p_status) else $error("status byte not driven");
   property p_write_nodrive;
      (pins == 3'b110) [*8] |-> !PARALLEL_DATA_LINES_OE;
   endproperty
   a_write_nodrive: assert property (p_write_nodrive) else $error("bus driven during write");
   property p_setup_hold;
      SETUP_VALID && !SETUP_READY |=> SETUP_VALID && $stable(SETUP_CODE);
   endproperty
   a_setup_hold: assert property (p_setup_hold) else $error("set-up code dropped");
   property p_rmw_save;
      $rose(RMW_ACTIVE) |-> $stable(COLUMN);
   endproperty
   a_rmw_save: assert property (p_rmw_save) else $error("column moved on mode entry");
   property p_rmw_restore;
      $fell(RMW_ACTIVE) |-> COLUMN == saved_r;
   endproperty
   a_rmw_restore: assert property (p_rmw_restore) else $error("column not restored");
endmodule

bind lcd_command_port lcd_port_props #(.COLS(COLS)) i_props (.CLOCK(CLOCK), .RST_N(RST_N),
   .CMD_DATA_SEL(CMD_DATA_SEL), .ENABLE_READ(ENABLE_READ), .READ_WRITE_SEL(READ_WRITE_SEL),
   .PARALLEL_DATA_LINES_OUT(PARALLEL_DATA_LINES_OUT), .PARALLEL_DATA_LINES_OE(PARALLEL_DATA_LINES_OE),
   .COLUMN(COLUMN), .PAGE(PAGE), .START_LINE(START_LINE), .RMW_ACTIVE(RMW_ACTIVE),
   .SETUP_VALID(SETUP_VALID), .SETUP_CODE(SETUP_CODE), .SETUP_READY(SETUP_READY),
   .COLUMN_LOAD(COLUMN_LOAD), .PAGE_LOAD(PAGE_LOAD), .START_LINE_LOAD(START_LINE_LOAD));

/* File: verification/host_model.sv */
/*
   Host microcontroller on the parallel bus: data and command writes, data and status reads.
   Assumes the caller spaces nothing itself; each access keeps the cycle above 40 clocks.
*/
`timescale 1ns/1ps
module host_model (
   input wire logic clock,
   input wire logic [7:0] dev_out,
   input wire logic dev_oe,
   output logic cd,
   output logic en,
   output logic rw,
   output wire logic [7:0] bus
);
   logic [7:0] drv;
   logic host_oe;
   // A released bus shows the inverse of the last byte, so a stale copy is never read as valid.
   assign bus = dev_oe ? dev_out : (host_oe ? drv : ~drv);
   // Pins start idle.
   initial begin
      cd = 1'b0;
      en = 1'b0;
      rw = 1'b0;
      drv = 8'h00;
      host_oe = 1'b0;
   end
   // Hold the level long enough for the synchroniser, sample late in it, then idle.
   task automatic access(input logic [2:0] p, input logic [7:0] val, output logic [7:0] seen);
      @(negedge clock);
      cd = p[2];
      en = p[1];
      rw = p[0];
      drv = val;
      host_oe = !p[0];
      repeat (12) @(negedge clock);
      seen = bus;
      cd = 1'b0;
      en = 1'b0;
      rw = 1'b0;
      host_oe = 1'b0;
      repeat (34) @(negedge clock);
   endtask
   task automatic wr_data(input logic [7:0] d);
      logic [7:0] s;
      access(3'b110, d, s);
   endtask
   task automatic wr_cmd(input logic [7:0] c);
      logic [7:0] s;
      access(3'b010, c, s);
   endtask
   task automatic rd_data(output logic [7:0] v);
      access(3'b101, 8'h00, v);
   endtask
   task automatic rd_status(output logic [7:0] v);
      access(3'b001, 8'h00, v);
   endtask
endmodule

/* File: verification/testbench.sv */
/*
   Self-checking bench for the command port: write and read-back rows, read-modify-write,
   soft and hard reset, and refusal while the queue is full. Assumes the host model beside it.
*/
`timescale 1ns/1ps
`include "lcd_port_params.svh"
module testbench;
   import lcd_port_pkg::*;
   typedef struct packed {logic [6:0] col; logic [1:0] page; logic [7:0] data;} row_type;
   logic clock, rst_n, setup_ready, column_load, page_load, start_line_load;
   logic [6:0] column_value;
   logic [1:0] page_value;
   logic [4:0] start_line_value;
   wire logic cd, en, rw, oe, busy, rmw_active, setup_valid;
   wire logic [7:0] bus, dout, setup_code;
   wire logic [6:0] column;
   wire logic [1:0] page;
   wire logic [4:0] start_line;
   int err_total = 0;
   int cmp_count = 0;
   logic [7:0] v;
   logic [7:0] codes[$];
   // Rows 0 and 1 share a column on two pages; the hard reset test reads row 0 back to prove they stay apart.
   row_type rows[5] = '{'{7'h00, 2'h0, 8'h3c}, '{7'h00, 2'h1, 8'hc3}, '{7'h40, 2'h2, 8'h81},
      '{7'h4f, 2'h3, 8'h7e}, '{7'h50, 2'h3, 8'h11}};

   host_model i_host (.clock(clock), .dev_out(dout), .dev_oe(oe), .cd(cd), .en(en), .rw(rw), .bus(bus));
   lcd_command_port i_dut (.CLOCK(clock), .RST_N(rst_n), .CMD_DATA_SEL(cd), .ENABLE_READ(en),
      .READ_WRITE_SEL(rw), .PARALLEL_DATA_LINES_IN(bus), .PARALLEL_DATA_LINES_OUT(dout),
      .PARALLEL_DATA_LINES_OE(oe), .BUSY(busy), .COLUMN(column), .PAGE(page), .START_LINE(start_line),
      .RMW_ACTIVE(rmw_active), .SETUP_VALID(setup_valid), .SETUP_CODE(setup_code),
      .SETUP_READY(setup_ready), .COLUMN_LOAD(column_load), .COLUMN_VALUE(column_value),
      .PAGE_LOAD(page_load), .PAGE_VALUE(page_value), .START_LINE_LOAD(start_line_load),
      .START_LINE_VALUE(start_line_value));

   //////////////////////////////////////////////////////////////////////
   // Compare, count and report.
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Column after n steps; it stops at the last column instead of wrapping.
   function automatic logic [7:0] step(input logic [6:0] c, input int n);
      return (c + n > `COL_COUNT - 1) ? 8'(`COL_COUNT - 1) : 8'(c + n);
   endfunction
   // The set-up decoder's load pulses, one cycle wide.
   task automatic set_ptr(input logic [6:0] c, input logic [1:0] p);
      @(negedge clock);
      column_load = 1'b1;
      page_load = 1'b1;
      column_value = c;
      page_value = p;
      @(negedge clock);
      column_load = 1'b0;
      page_load = 1'b0;
      repeat (3) @(negedge clock);
   endtask

   //////////////////////////////////////////////////////////////////////
   // Free-running clock.
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // Accepted set-up codes, in order.
   always @(posedge clock) begin
      if (setup_valid === 1'b1 && setup_ready) begin
         codes.push_back(setup_code);
      end
   end
   // Watchdog, well beyond the roughly 1950 cycles the sequence needs.
   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      test_done;
   end
   // Main sequence.
   initial begin
      rst_n = 1'b0;
      setup_ready = 1'b1;
      column_load = 1'b0;
      page_load = 1'b0;
      start_line_load = 1'b0;
      column_value = 7'h00;
      page_value = 2'h0;
      start_line_value = 5'h00;
      repeat (6) @(negedge clock);
      rst_n = 1'b1;
      repeat (6) @(negedge clock);
      chk("reset col", {1'b0, column}, 8'h00);
      chk("reset mode", {7'h00, rmw_active}, 8'h00);
      chk("reset oe", {7'h00, oe}, 8'h00);
      // Each byte goes in twice, so the neighbour that the second read loads into the latch is never
      // an unwritten cell, whose unknown content would otherwise reach the bus on the next read.
      foreach (rows[i]) begin
         set_ptr(rows[i].col, rows[i].page);
         i_host.wr_data(rows[i].data);
         i_host.wr_data(rows[i].data);
         chk("wr col", {1'b0, column}, step(rows[i].col, 2));
         set_ptr(rows[i].col, rows[i].page);
         i_host.rd_data(v);
         i_host.rd_data(v);
         chk("rd data", v, rows[i].data);
         chk("rd col", {1'b0, column}, step(rows[i].col, 2));
      end
      // Read-modify-write with a soft reset in the middle of it.
      set_ptr(7'h10, 2'h0);
      i_host.wr_data(8'ha5);
      set_ptr(7'h10, 2'h0);
      i_host.wr_cmd(`CMD_RMW_ENTER);
      chk("rmw on", {7'h00, rmw_active}, 8'h01);
      i_host.rd_data(v);
      i_host.rd_data(v);
      chk("rmw rd", v, 8'ha5);
      chk("rmw rd col", {1'b0, column}, 8'h10);
      i_host.wr_data(8'h5a);
      chk("rmw wr col", {1'b0, column}, 8'h11);
      @(negedge clock);
      start_line_load = 1'b1;
      start_line_value = 5'h07;
      @(negedge clock);
      start_line_load = 1'b0;
      chk("rmw start", {3'h0, start_line}, 8'h07);
      i_host.wr_cmd(`CMD_SOFT_RESET);
      chk("soft page", {6'h00, page}, {6'h00, `PAGE_SOFT_RESET});
      chk("soft start", {3'h0, start_line}, 8'h00);
      chk("soft col", {1'b0, column}, 8'h11);
      chk("soft mode", {7'h00, rmw_active}, 8'h01);
      i_host.wr_cmd(`CMD_RMW_END);
      chk("end col", {1'b0, column}, 8'h10);
      chk("end mode", {7'h00, rmw_active}, 8'h00);
      i_host.wr_cmd(`CMD_RMW_END);
      chk("stray end", {1'b0, column}, 8'h10);
      set_ptr(7'h10, 2'h0);
      i_host.rd_data(v);
      i_host.rd_data(v);
      chk("kept mem", v, 8'h5a);
      // Stall the set-up decoder until the queue refuses.
      @(negedge clock);
      setup_ready = 1'b0;
      codes.delete();
      i_host.wr_cmd(8'h40);
      i_host.wr_cmd(8'h41);
      i_host.wr_cmd(8'h42);
      chk("busy", {7'h00, busy}, 8'h01);
      i_host.rd_status(v);
      chk("status busy", v, 8'h80);
      i_host.wr_data(8'hff);
      setup_ready = 1'b1;
      repeat (10) @(negedge clock);
      chk("refused col", {1'b0, column}, 8'h12);
      chk("codes", 8'(codes.size()), 8'h03);
      foreach (codes[i]) chk("code", codes[i], 8'h40 + 8'(i));
      chk("codes mode", {7'h00, rmw_active}, 8'h00);
      i_host.rd_status(v);
      chk("status idle", v, 8'h00);
      set_ptr(7'h7f, 2'h0);
      chk("clamp col", {1'b0, column}, 8'h50);
      // Hard reset in the middle of read-modify-write.
      i_host.wr_cmd(`CMD_RMW_ENTER);
      @(negedge clock);
      rst_n = 1'b0;
      repeat (2) @(negedge clock);
      rst_n = 1'b1;
      repeat (6) @(negedge clock);
      chk("hw mode", {7'h00, rmw_active}, 8'h00);
      i_host.rd_data(v);
      chk("dummy", v, `LATCH_RESET);
      chk("hw rd col", {1'b0, column}, 8'h01);
      i_host.rd_data(v);
      chk("page split", v, 8'h3c);
      test_done;
   end
endmodule
